/* File: hw/frpc_pkg.sv */
/*
  Package for the frequency ramp profile controller: encodings, reset values,
  timing and scaling constants, and the settings carrier struct.
  Assumes frequencies in 0.01 Hz units, times in 0.1 s units, percent in 1 %.
*/
package frpc_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // Control tick period in microseconds, cycles derived from the clock rate
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;
  // Hold time unit 0.1 s expressed in ticks
  localparam logic [15:0] HOLD_UNIT_TICKS = 16'h0064;
  localparam logic [15:0] SETTING_DISABLED = 16'h270f;
  localparam logic [15:0] HOLD_MAX = 16'h0064;
  localparam logic [15:0] REF_CURRENT_MAX = 16'h01f4;
  localparam logic [15:0] LIMIT_MAX = 16'h00c8;
  localparam logic [15:0] LIMIT_DEFAULT = 16'h0096;
  localparam logic [15:0] MIN_HOLD_FREQ = 16'h0001;
  localparam logic [15:0] GROUP_WRITE_OK = 16'h0000;
  localparam logic [15:0] RATED_CURRENT_DEFAULT = 16'h0064;
  localparam logic [15:0] LAUNCH_FREQ_DEFAULT = 16'h0032;
  localparam logic [15:0] BASE_FREQ_DEFAULT = 16'h1388;
  localparam logic [15:0] REF_FREQ_DEFAULT = 16'h1388;
  localparam logic [15:0] TIME_DEFAULT = 16'h0032;
  // Shortest mode nominal time fraction in 1/16 of the set time
  localparam logic [4:0] SHORT_NUM_BRAKE = 5'h04;
  localparam logic [4:0] SHORT_NUM_PLAIN = 5'h08;
  localparam logic [4:0] SHORT_DEN = 5'h10;

  typedef enum logic [1:0] {
    FRPC_SHAPE_LINEAR = 2'h0,
    FRPC_SHAPE_S_BASE = 2'h1,
    FRPC_SHAPE_S_EACH = 2'h2
  } frpc_shape_e;

  localparam logic [7:0] AUTO_NORMAL = 8'h00;
  localparam logic [7:0] AUTO_SHORT = 8'h01;
  localparam logic [7:0] AUTO_SHORT_BRAKE = 8'h0b;
  localparam logic [7:0] AUTO_BRAKE_SEQ1 = 8'h07;
  localparam logic [7:0] AUTO_BRAKE_SEQ2 = 8'h08;

  localparam logic [1:0] DIR_BOTH = 2'h0;
  localparam logic [1:0] DIR_ACCEL = 2'h1;
  localparam logic [1:0] DIR_DECEL = 2'h2;

  typedef enum logic [3:0] {
    FRPC_ST_STOP = 4'b0001,
    FRPC_ST_HOLD = 4'b0010,
    FRPC_ST_RAMP = 4'b0100,
    FRPC_ST_DECEL = 4'b1000
  } frpc_state_e;

  typedef struct packed {
    logic [15:0] start_hold_duration;
    logic [15:0] launch_frequency;
    logic [1:0] ramp_shape_select;
    logic [15:0] base_frequency_setting;
    logic [15:0] ramp_reference_frequency;
    logic [15:0] accel_time_setting;
    logic [15:0] decel_time_setting;
    logic [7:0] auto_ramp_mode;
    logic [1:0] auto_ramp_direction_select;
    logic [15:0] auto_ramp_reference_current;
    logic [15:0] accel_current_limit;
    logic [15:0] decel_current_limit;
    logic [15:0] stall_prevention_level;
  } frpc_settings_s;
endpackage

/* File: hw/frpc_step_calc.sv */
/*
  Ramp step calculator: frequency increment per tick for one ramp.
  Assumes inputs stable for the cycle in which the step is latched.
*/
`timescale 1ns/10ps
module frpc_step_calc
  import frpc_pkg::*;
(
  // Ramp span and time
  input wire logic [15:0] span_freq,
  input wire logic [15:0] time_setting,
  // Shortest mode scaling
  input wire logic short_en,
  input wire logic short_brake,
  // Result
  output logic [15:0] step
);
  logic [31:0] ticks;
  logic [31:0] ticks_eff;
  logic [31:0] quot;

  always_comb
  begin
    ticks = time_setting * HOLD_UNIT_TICKS;
    // Shortest mode derives a shorter ramp time, settings left intact
    if (short_en)
    begin
      ticks_eff = (ticks * (short_brake ? SHORT_NUM_BRAKE : SHORT_NUM_PLAIN)) / SHORT_DEN;
    end
    else
    begin
      ticks_eff = ticks;
    end
    if (ticks_eff == 32'h0)
    begin
      quot = {16'h0, span_freq};
    end
    else
    begin
      quot = ({16'h0, span_freq} + ticks_eff - 32'h1) / ticks_eff;
    end
    step = (quot == 32'h0) ? 16'h1 : quot[15:0];
  end
endmodule

/* File: hw/frpc_ramp_ctrl.sv */
/*
  Frequency ramp profile controller top: settings store, start hold,
  linear and S-shaped ramps, shortest ramp mode with current limits.
  Assumes all inputs synchronous to clock; one write strobe for the whole settings struct.
*/
`timescale 1ns/10ps
module frpc_ramp_ctrl
  import frpc_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES,
  parameter logic [15:0] RATED_CURRENT = RATED_CURRENT_DEFAULT
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Setting writes
  input wire logic wr_en,
  input wire frpc_settings_s wr_data,
  input wire logic [15:0] user_group_read_select,
  // Run commands
  input wire logic start_cmd,
  input wire logic reverse_cmd,
  input wire logic [15:0] command_freq,
  input wire logic inching_select,
  input wire logic second_set_select,
  // Outputs
  output logic [15:0] out_freq_q,
  output logic out_reverse_q,
  output logic running_q,
  output logic shortest_active_q,
  output logic [15:0] stall_level_q,
  output frpc_settings_s settings_q
);
  frpc_state_e state_q;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic [31:0] hold_cnt_q;
  logic [15:0] target_q;
  logic [15:0] from_q;
  logic [15:0] step_q;
  logic [1:0] shape_q;
  logic short_acc_q;
  logic short_dec_q;
  logic auto_off_q;
  logic [15:0] step_w;
  logic [15:0] span_w;
  logic [15:0] time_w;
  logic [15:0] launch_w;
  logic accel_w;
  logic short_w;
  logic brake_w;
  logic short_dir_w;
  logic [7:0] mode_w;
  logic [15:0] cur_step;
  logic [15:0] want_freq;
  logic start_ok;
  logic reverse_req;
  logic [15:0] dist_lo;
  logic [15:0] dist_hi;

  // Control tick
  always_ff @(posedge clock)
  begin
    if (rst || tick_cnt_q == TICK_LEN - 1)
      tick_cnt_q <= 32'h0;
    else
      tick_cnt_q <= tick_cnt_q + 32'h1;
  end
  assign tick = (tick_cnt_q == TICK_LEN - 1);

  // Settings store
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      settings_q.start_hold_duration <= SETTING_DISABLED;
      settings_q.launch_frequency <= LAUNCH_FREQ_DEFAULT;
      settings_q.ramp_shape_select <= FRPC_SHAPE_LINEAR;
      settings_q.base_frequency_setting <= BASE_FREQ_DEFAULT;
      settings_q.ramp_reference_frequency <= REF_FREQ_DEFAULT;
      settings_q.accel_time_setting <= TIME_DEFAULT;
      settings_q.decel_time_setting <= TIME_DEFAULT;
      settings_q.auto_ramp_mode <= AUTO_NORMAL;
      settings_q.auto_ramp_direction_select <= DIR_BOTH;
      settings_q.auto_ramp_reference_current <= SETTING_DISABLED;
      settings_q.accel_current_limit <= SETTING_DISABLED;
      settings_q.decel_current_limit <= SETTING_DISABLED;
      settings_q.stall_prevention_level <= LIMIT_DEFAULT;
    end
    else if (wr_en && user_group_read_select == GROUP_WRITE_OK)
    begin
      if (wr_data.start_hold_duration <= HOLD_MAX ||
          wr_data.start_hold_duration == SETTING_DISABLED)
        settings_q.start_hold_duration <= wr_data.start_hold_duration;
      settings_q.launch_frequency <= wr_data.launch_frequency;
      if (wr_data.ramp_shape_select <= FRPC_SHAPE_S_EACH)
        settings_q.ramp_shape_select <= wr_data.ramp_shape_select;
      settings_q.base_frequency_setting <= wr_data.base_frequency_setting;
      settings_q.ramp_reference_frequency <= wr_data.ramp_reference_frequency;
      settings_q.accel_time_setting <= wr_data.accel_time_setting;
      settings_q.decel_time_setting <= wr_data.decel_time_setting;
      if (wr_data.auto_ramp_direction_select <= DIR_DECEL)
        settings_q.auto_ramp_direction_select <= wr_data.auto_ramp_direction_select;
      settings_q.stall_prevention_level <= wr_data.stall_prevention_level;
      if (wr_data.auto_ramp_mode != settings_q.auto_ramp_mode &&
          (wr_data.auto_ramp_mode == AUTO_NORMAL || wr_data.auto_ramp_mode == AUTO_SHORT ||
           wr_data.auto_ramp_mode == AUTO_SHORT_BRAKE ||
           wr_data.auto_ramp_mode == AUTO_BRAKE_SEQ1 ||
           wr_data.auto_ramp_mode == AUTO_BRAKE_SEQ2))
      begin
        settings_q.auto_ramp_mode <= wr_data.auto_ramp_mode;
        settings_q.auto_ramp_reference_current <= SETTING_DISABLED;
        settings_q.accel_current_limit <= SETTING_DISABLED;
        settings_q.decel_current_limit <= SETTING_DISABLED;
      end
      else
      begin
        if (wr_data.auto_ramp_reference_current <= REF_CURRENT_MAX ||
            wr_data.auto_ramp_reference_current == SETTING_DISABLED)
          settings_q.auto_ramp_reference_current <= wr_data.auto_ramp_reference_current;
        if (wr_data.accel_current_limit <= LIMIT_MAX ||
            wr_data.accel_current_limit == SETTING_DISABLED)
          settings_q.accel_current_limit <= wr_data.accel_current_limit;
        if (wr_data.decel_current_limit <= LIMIT_MAX ||
            wr_data.decel_current_limit == SETTING_DISABLED)
          settings_q.decel_current_limit <= wr_data.decel_current_limit;
      end
    end
  end

  // Inching or second set while stopped forces normal mode
  always_ff @(posedge clock)
  begin
    if (rst)
      auto_off_q <= 1'b0;
    else if (state_q == FRPC_ST_STOP)
      auto_off_q <= inching_select || second_set_select;
  end

  // Ramp setup
  assign mode_w = auto_off_q ? AUTO_NORMAL : settings_q.auto_ramp_mode;
  assign short_w = (mode_w == AUTO_SHORT) || (mode_w == AUTO_SHORT_BRAKE);
  assign brake_w = (mode_w == AUTO_SHORT_BRAKE);
  assign short_dir_w = short_w && (settings_q.auto_ramp_direction_select !=
                       (accel_w ? DIR_DECEL : DIR_ACCEL));
  assign launch_w = (settings_q.launch_frequency == 16'h0) ? MIN_HOLD_FREQ
                    : settings_q.launch_frequency;
  assign start_ok = start_cmd && command_freq >= settings_q.launch_frequency;
  assign want_freq = (start_ok && !reverse_req) ? command_freq : 16'h0;
  assign reverse_req = running_q && (reverse_cmd != out_reverse_q);
  assign accel_w = want_freq > out_freq_q;
  // Shape 1 uses base frequency as the time reference
  assign span_w = (settings_q.ramp_shape_select == FRPC_SHAPE_S_BASE)
                  ? settings_q.base_frequency_setting
                  : settings_q.ramp_reference_frequency;
  assign time_w = accel_w ? settings_q.accel_time_setting : settings_q.decel_time_setting;

  frpc_step_calc u_step (
    .span_freq(span_w),
    .time_setting(time_w),
    .short_en(short_dir_w),
    .short_brake(brake_w && !accel_w),
    .step(step_w)
  );

  // Stall prevention level during ramps and at constant speed
  always_ff @(posedge clock)
  begin
    if (rst)
      stall_level_q <= LIMIT_DEFAULT;
    else if (shortest_active_q && out_freq_q != target_q &&
             (state_q == FRPC_ST_RAMP || state_q == FRPC_ST_DECEL))
    begin
      if (accel_w)
        stall_level_q <= (settings_q.accel_current_limit == SETTING_DISABLED)
                         ? LIMIT_DEFAULT : settings_q.accel_current_limit;
      else
        stall_level_q <= (settings_q.decel_current_limit == SETTING_DISABLED)
                         ? LIMIT_DEFAULT : settings_q.decel_current_limit;
    end
    else
      stall_level_q <= settings_q.stall_prevention_level;
  end

  // S-curve step shaping
  always_comb
  begin
    dist_lo = out_freq_q > from_q ? out_freq_q - from_q : from_q - out_freq_q;
    dist_hi = out_freq_q > target_q ? out_freq_q - target_q : target_q - out_freq_q;
    cur_step = step_q;
    case (shape_q)
      FRPC_SHAPE_S_BASE:
      begin
        // Soft start below base, steady rate above
        if (out_freq_q < settings_q.base_frequency_setting)
          cur_step = (dist_lo < step_q) ? {1'b0, step_q[15:1]} : step_q;
        else
          cur_step = step_q;
      end
      FRPC_SHAPE_S_EACH:
      begin
        // Soft ends, double rate mid-ramp keeps total under linear
        if (dist_lo < step_q || dist_hi < step_q)
          cur_step = (step_q > 16'h1) ? {1'b0, step_q[15:1]} : step_q;
        else
          cur_step = {step_q[14:0], 1'b0};
      end
      default:
        cur_step = step_q;
    endcase
    if (cur_step == 16'h0)
      cur_step = 16'h1;
  end

  // Ramp state machine
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= FRPC_ST_STOP;
      out_freq_q <= 16'h0;
      out_reverse_q <= 1'b0;
      running_q <= 1'b0;
      hold_cnt_q <= 32'h0;
      target_q <= 16'h0;
      from_q <= 16'h0;
      step_q <= 16'h1;
      shape_q <= FRPC_SHAPE_LINEAR;
      shortest_active_q <= 1'b0;
    end
    else if (tick)
    begin
      case (state_q)
        FRPC_ST_STOP:
        begin
          if (start_ok)
          begin
            out_freq_q <= launch_w;
            out_reverse_q <= reverse_cmd;
            running_q <= 1'b1;
            hold_cnt_q <= settings_q.start_hold_duration * HOLD_UNIT_TICKS;
            if (settings_q.start_hold_duration != SETTING_DISABLED)
              state_q <= FRPC_ST_HOLD;
            else
              state_q <= FRPC_ST_RAMP;
            target_q <= launch_w;
          end
        end
        FRPC_ST_HOLD:
        begin
          if (!start_cmd)
          begin
            state_q <= FRPC_ST_DECEL;
            target_q <= 16'h0;
            from_q <= out_freq_q;
            step_q <= step_w;
          end
          else if (hold_cnt_q <= 32'h1)
            state_q <= FRPC_ST_RAMP;
          else
            hold_cnt_q <= hold_cnt_q - 32'h1;
        end
        FRPC_ST_RAMP, FRPC_ST_DECEL:
        begin
          if (want_freq != target_q)
          begin
            target_q <= want_freq;
            from_q <= out_freq_q;
            step_q <= step_w;
            shape_q <= settings_q.ramp_shape_select;
            shortest_active_q <= short_dir_w;
            state_q <= accel_w ? FRPC_ST_RAMP : FRPC_ST_DECEL;
          end
          else if (out_freq_q < target_q)
            out_freq_q <= (target_q - out_freq_q < cur_step) ? target_q
                          : out_freq_q + cur_step;
          else if (out_freq_q > target_q)
            out_freq_q <= (out_freq_q - target_q < cur_step) ? target_q
                          : out_freq_q - cur_step;
          else if (target_q == 16'h0)
          begin
            if (reverse_req && start_ok)
            begin
              out_freq_q <= launch_w;
              out_reverse_q <= reverse_cmd;
              target_q <= launch_w;
              state_q <= FRPC_ST_RAMP;
            end
            else
            begin
              running_q <= 1'b0;
              state_q <= FRPC_ST_STOP;
            end
          end
        end
        default:
          state_q <= FRPC_ST_STOP;
      endcase
    end
  end

  // Checks
  sequence s_hold_begin;
    state_q == FRPC_ST_STOP && tick && start_ok &&
      settings_q.start_hold_duration != SETTING_DISABLED;
  endsequence
  a_hold_entry: assert property (@(posedge clock) disable iff (rst)
    s_hold_begin |=> state_q == FRPC_ST_HOLD && out_freq_q == launch_w)
    else $error("hold not entered at launch frequency");
  a_hold_abort: assert property (@(posedge clock) disable iff (rst)
    state_q == FRPC_ST_HOLD && tick && !start_cmd |=> state_q == FRPC_ST_DECEL)
    else $error("hold not abandoned on start removal");
  a_zero_launch: assert property (@(posedge clock) disable iff (rst)
    state_q == FRPC_ST_HOLD |-> out_freq_q != 16'h0)
    else $error("hold frequency zero");
  a_no_start_low: assert property (@(posedge clock) disable iff (rst)
    state_q == FRPC_ST_STOP && command_freq < settings_q.launch_frequency
      |=> state_q == FRPC_ST_STOP)
    else $error("started below launch frequency");
  a_write_locked: assert property (@(posedge clock) disable iff (rst)
    user_group_read_select != GROUP_WRITE_OK |=> $stable(settings_q))
    else $error("setting changed while locked");
  a_mode_resets: assert property (@(posedge clock) disable iff (rst)
    $changed(settings_q.auto_ramp_mode) |-> settings_q.accel_current_limit == SETTING_DISABLED)
    else $error("limits not reset on mode change");
  a_limit_range: assert property (@(posedge clock) disable iff (rst)
    settings_q.decel_current_limit <= LIMIT_MAX ||
      settings_q.decel_current_limit == SETTING_DISABLED)
    else $error("limit out of range");
  a_ramp_on_tick: assert property (@(posedge clock) disable iff (rst)
    !$past(tick) |-> $stable(out_freq_q))
    else $error("frequency moved off tick");
  a_const_stall: assert property (@(posedge clock) disable iff (rst)
    state_q == FRPC_ST_HOLD ##1 state_q == FRPC_ST_HOLD
      |-> stall_level_q == settings_q.stall_prevention_level)
    else $error("constant speed stall level wrong");
endmodule

/* File: sim/frpc_motor_model.sv */
/*
  Behavioural motor on the drive output: shaft speed trails the applied frequency.
  Assumes the frequency comes straight from the controller output register.
*/
`timescale 1ns/10ps
module frpc_motor_model
#(
  parameter int LAG = 2
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Drive output
  input wire logic [15:0] freq,
  // Shaft state
  output logic [15:0] speed
);
  int cnt;

  // Speed creeps toward the applied frequency, one step per LAG+1 cycles
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      speed <= 16'h0000;
      cnt <= 0;
    end
    else if (cnt >= LAG)
    begin
      cnt <= 0;
      if (speed < freq)
        speed <= speed + 16'h0001;
      else if (speed > freq)
        speed <= speed - 16'h0001;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

/* File: sim/frpc_ramp_ctrl_tb_top.sv */
/*
  Self-checking bench for the frequency ramp profile controller.
  Assumes a control tick shortened to four clock cycles.
*/
`timescale 1ns/10ps
module frpc_ramp_ctrl_tb_top;
  import frpc_pkg::*;
  localparam int TL = 4;
  logic clock, rst, wr_en, start_cmd, reverse_cmd, inching_select, second_set_select;
  logic [15:0] user_group_read_select, command_freq, out_freq_q, stall_level_q, speed;
  logic out_reverse_q, running_q, shortest_active_q;
  logic [15:0] a, b, c;
  frpc_settings_s wr_data, settings_q, cfg;
  int n_errors, compares, n, na;

  frpc_ramp_ctrl #(.TICK_LEN(TL)) i_dut (.clock(clock), .rst(rst), .wr_en(wr_en),
    .wr_data(wr_data), .user_group_read_select(user_group_read_select),
    .start_cmd(start_cmd), .reverse_cmd(reverse_cmd), .command_freq(command_freq),
    .inching_select(inching_select), .second_set_select(second_set_select),
    .out_freq_q(out_freq_q), .out_reverse_q(out_reverse_q), .running_q(running_q),
    .shortest_active_q(shortest_active_q), .stall_level_q(stall_level_q),
    .settings_q(settings_q));
  frpc_motor_model i_motor (.clock(clock), .rst(rst), .freq(out_freq_q), .speed(speed));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tk(input int k);
    repeat (k * TL) @(negedge clock);
  endtask

  task automatic wr(input frpc_settings_s s);
    wr_data = s;
    wr_en = 1'b1;
    @(negedge clock);
    wr_en = 1'b0;
    @(negedge clock);
  endtask

  task automatic go(input logic [15:0] f);
    command_freq = f;
    start_cmd = 1'b1;
    n = 0;
    while (running_q !== 1'b1 && n < 20)
    begin
      tk(1);
      n++;
    end
  endtask

  // Rising targets end at or above f, a zero target ends at zero
  task automatic reach(input logic [15:0] f);
    n = 0;
    while (n < 3000 && (f == 16'h0000 ? out_freq_q !== f : out_freq_q < f))
    begin
      tk(1);
      n++;
    end
  endtask

  task automatic stop();
    start_cmd = 1'b0;
    reverse_cmd = 1'b0;
    reach(16'h0000);
    tk(2);
  endtask

  task automatic t_reset();
    chk(settings_q.start_hold_duration, SETTING_DISABLED);
    chk(settings_q.auto_ramp_reference_current, SETTING_DISABLED);
    chk(settings_q.accel_current_limit, SETTING_DISABLED);
    chk({8'h00, settings_q.auto_ramp_mode}, {8'h00, AUTO_NORMAL});
    chk(16'(settings_q.auto_ramp_direction_select), 16'(DIR_BOTH));
    chk(16'(settings_q.ramp_shape_select), 16'h0000);
    chk(stall_level_q, LIMIT_DEFAULT);
  endtask

  task automatic t_lock();
    cfg = settings_q;
    cfg.accel_time_setting = 16'h0001;
    cfg.decel_time_setting = 16'h0001;
    user_group_read_select = 16'h0001;
    wr(cfg);
    chk(settings_q.accel_time_setting, TIME_DEFAULT);
    user_group_read_select = 16'h0000;
    cfg.start_hold_duration = 16'h0065;
    wr(cfg);
    chk(settings_q.accel_time_setting, 16'h0001);
    chk(settings_q.start_hold_duration, SETTING_DISABLED);
  endtask

  task automatic t_mode();
    cfg = settings_q;
    cfg.auto_ramp_mode = AUTO_SHORT;
    cfg.auto_ramp_reference_current = 16'h00c8;
    wr(cfg);
    chk(settings_q.auto_ramp_reference_current, SETTING_DISABLED);
    cfg.accel_current_limit = 16'h0078;
    cfg.decel_current_limit = 16'h0082;
    wr(cfg);
    chk(settings_q.auto_ramp_reference_current, 16'h00c8);
    chk(settings_q.accel_current_limit, 16'h0078);
    cfg.auto_ramp_reference_current = 16'h01f5;
    cfg.decel_current_limit = 16'h00c9;
    wr(cfg);
    chk(settings_q.auto_ramp_reference_current, 16'h00c8);
    chk(settings_q.decel_current_limit, 16'h0082);
    cfg = settings_q;
    cfg.auto_ramp_mode = AUTO_NORMAL;
    wr(cfg);
    chk(settings_q.decel_current_limit, SETTING_DISABLED);
  endtask

  task automatic t_hold();
    command_freq = 16'h0028;
    start_cmd = 1'b1;
    tk(5);
    chk(16'(running_q), 16'h0000);
    start_cmd = 1'b0;
    cfg = settings_q;
    cfg.launch_frequency = 16'h0000;
    cfg.start_hold_duration = 16'h0001;
    wr(cfg);
    go(16'h03e8);
    chk(out_freq_q, MIN_HOLD_FREQ);
    tk(90);
    chk(out_freq_q, MIN_HOLD_FREQ);
    tk(20);
    chk(16'(out_freq_q > MIN_HOLD_FREQ), 16'h0001);
    stop();
    cfg.launch_frequency = 16'h01f4;
    wr(cfg);
    go(16'h03e8);
    tk(20);
    stop();
    chk(16'(n < 20), 16'h0001);
    chk(16'(running_q), 16'h0000);
  endtask

  task automatic t_linear();
    cfg.launch_frequency = LAUNCH_FREQ_DEFAULT;
    cfg.start_hold_duration = SETTING_DISABLED;
    wr(cfg);
    go(16'h1388);
    tk(20);
    a = out_freq_q;
    tk(1);
    b = out_freq_q;
    tk(1);
    c = out_freq_q;
    chk(c - b, b - a);
    reach(16'h1388);
    na = n + 22;
    chk(16'(na > 90 && na < 110), 16'h0001);
    chk(16'(speed != 16'h0000 && speed < out_freq_q), 16'h0001);
    cfg.start_hold_duration = 16'h0001;
    wr(cfg);
    reverse_cmd = 1'b1;
    n = 0;
    while (out_reverse_q !== 1'b1 && n < 2000)
    begin
      @(negedge clock);
      n++;
    end
    chk(out_freq_q, LAUNCH_FREQ_DEFAULT);
    tk(5);
    chk(16'(out_freq_q > LAUNCH_FREQ_DEFAULT), 16'h0001);
    stop();
  endtask

  task automatic t_shapes();
    cfg.start_hold_duration = SETTING_DISABLED;
    cfg.ramp_shape_select = 2'h2;
    wr(cfg);
    go(16'h0bb8);
    reach(16'h0bb8);
    command_freq = 16'h1388;
    reach(16'h1388);
    chk(16'(n <= 41), 16'h0001);
    stop();
    cfg.ramp_shape_select = 2'h1;
    cfg.base_frequency_setting = 16'h09c4;
    wr(cfg);
    go(16'h1388);
    reach(16'h09c4);
    chk(16'(n > 90 && n < 110), 16'h0001);
    reach(16'h1388);
    chk(out_freq_q, 16'h1388);
    stop();
    cfg.ramp_shape_select = 2'h0;
    cfg.base_frequency_setting = BASE_FREQ_DEFAULT;
  endtask

  task automatic t_short();
    cfg.stall_prevention_level = 16'h0064;
    for (int i = 0; i < 4; i++)
    begin
      cfg.auto_ramp_mode = (i == 3) ? AUTO_SHORT_BRAKE : AUTO_SHORT;
      cfg.auto_ramp_direction_select = (i == 3) ? DIR_BOTH : 2'(i);
      wr(cfg);
      cfg.accel_current_limit = 16'h0078;
      cfg.decel_current_limit = 16'h0082;
      wr(cfg);
      go(16'h07d0);
      tk(2);
      chk(16'(shortest_active_q), 16'(i != 2));
      chk(stall_level_q, (i != 2) ? 16'h0078 : 16'h0064);
      reach(16'h07d0);
      tk(2);
      chk(stall_level_q, 16'h0064);
      start_cmd = 1'b0;
      tk(2);
      chk(16'(shortest_active_q), 16'(i != 1));
      chk(stall_level_q, (i != 1) ? 16'h0082 : 16'h0064);
      stop();
      chk(settings_q.accel_time_setting, 16'h0001);
    end
    go(16'h07d0);
    tk(2);
    inching_select = 1'b1;
    tk(2);
    inching_select = 1'b0;
    start_cmd = 1'b0;
    tk(2);
    chk(16'(shortest_active_q), 16'h0001);
    stop();
    second_set_select = 1'b1;
    tk(2);
    go(16'h07d0);
    second_set_select = 1'b0;
    tk(2);
    chk(16'(shortest_active_q), 16'h0000);
    stop();
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial
  begin
    #400000;
    n_errors++;
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    wr_en = 1'b0;
    wr_data = '0;
    user_group_read_select = 16'h0000;
    start_cmd = 1'b0;
    reverse_cmd = 1'b0;
    command_freq = 16'h0000;
    inching_select = 1'b0;
    second_set_select = 1'b0;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_reset();
    t_lock();
    t_mode();
    t_hold();
    t_linear();
    t_shapes();
    t_short();
    finish_test();
  end
endmodule
